// ### supply_level_monitor_regs.sv
// AHB-Lite register bank and crossing logic of the supply level monitor
// Functional notes
// RULE1: The two-bit level field turns the monitor off at zero and sets 5, 15 or 25 percent above.
// RULE2: The edge field at bits 2:1 picks falling, rising or either crossing; other codes are reserved.
// RULE3: The interrupt is enabled while enable bit zero of the interrupt control register is one.
// RULE4: The flag bit zero is set when the comparator crosses in the selected direction.
// RULE5: The flag only changes while the brown-out detector is enabled and holds otherwise.
// RULE6: All four registers reset to zero.
// RULE7: The interrupt request is high while enable and flag are both set, until the flag clears.
// RULE8: The interrupt request is withheld while the processor is halted in debug mode.
// RULE9: Writing one clears the flag, zero leaves it, and status reads one while below threshold.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module supply_level_monitor_regs
   import supply_level_monitor_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Analog side
   input  wire logic        supply_below_i,
   input  wire logic        brownout_enabled_i,
   input  wire logic        debug_halted_i,
   output logic [1:0]       monitor_level_sel_o,
   // Interrupt request
   output logic             monitor_irq_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      phase_type  phase;
      logic       wr_pend;
      logic [7:0] addr_idx;
      logic [1:0] level_sel;
      logic [1:0] edge_cfg;
      logic       irq_enable;
      logic       irq_flag;
      logic       below_prev;
      logic [31:0] rdata;
      logic       irq;
      logic       ready;
      logic       resp;
   } regs_state_type;

   regs_state_type state;
   regs_state_type next_state;
   logic           below_sync;
   logic           bod_sync;
   logic           dbg_sync;
   logic           cross_hit;
   logic           monitor_on;

   level_sync u_below_sync
   (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (supply_below_i),
      .sync_o    (below_sync)
   );

   level_sync u_bod_sync
   (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (brownout_enabled_i),
      .sync_o    (bod_sync)
   );

   level_sync u_dbg_sync
   (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (debug_halted_i),
      .sync_o    (dbg_sync)
   );

   // ----------------------------------------------------------------
   // Crossing detection
   // ----------------------------------------------------------------
   function automatic logic edge_match(input logic [1:0] cfg, input logic prev,
                                       input logic now);
      logic fell;
      logic rose;
      fell = !prev && now;
      rose = prev && !now;
      unique case (cfg)
         edge_falling: edge_match = fell;   // [RULE2]
         edge_rising:  edge_match = rose;   // [RULE2]
         edge_both:    edge_match = fell || rose;
         default:      edge_match = 1'b0;   // Reserved code triggers nothing
      endcase
   endfunction

   function automatic logic [31:0] read_mux(input regs_state_type s, input logic [7:0] idx,
                                            input logic below);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (idx)
         monitor_level_control_idx:     v[level_sel_lsb +: 2] = s.level_sel;
         monitor_interrupt_control_idx:
         begin
            v[edge_cfg_lsb +: 2]  = s.edge_cfg;
            v[irq_enable_bit]     = s.irq_enable;
         end
         monitor_interrupt_flags_idx:   v[irq_flag_bit] = s.irq_flag;
         monitor_status_idx:            v[below_bit] = below;   // [RULE9]
         default:                       v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   assign monitor_on = (state.level_sel != level_off);   // [RULE1]
   assign cross_hit  = monitor_on && edge_match(state.edge_cfg, state.below_prev, below_sync);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state            = state;
      next_state.below_prev = monitor_on ? below_sync : 1'b0;
      if (state.phase == phase_data && state.wr_pend)
      begin
         unique case (state.addr_idx)
            monitor_level_control_idx:
               next_state.level_sel = hwdata_i[level_sel_lsb +: 2];   // [RULE1]
            monitor_interrupt_control_idx:
            begin
               next_state.edge_cfg   = hwdata_i[edge_cfg_lsb +: 2];   // [RULE2]
               next_state.irq_enable = hwdata_i[irq_enable_bit];      // [RULE3]
            end
            monitor_interrupt_flags_idx:
               if (hwdata_i[irq_flag_bit] && bod_sync)
                  next_state.irq_flag = 1'b0;                         // [RULE9]
            default:
               next_state.level_sel = state.level_sel;
         endcase
      end
      // Set wins over a clear in the same cycle
      if (cross_hit && bod_sync)
         next_state.irq_flag = 1'b1;   // [RULE4] [RULE5]
      next_state.phase   = phase_idle;
      next_state.wr_pend = 1'b0;
      next_state.ready   = 1'b1;
      next_state.resp    = 1'b0;
      if (hsel_i && hready_i && htrans_i == htrans_nonseq)
      begin
         next_state.phase    = phase_data;
         next_state.wr_pend  = hwrite_i;
         next_state.addr_idx = haddr_i[9:2];
         next_state.rdata    = read_mux(state, haddr_i[9:2], monitor_on && below_sync);
      end
      // Debug halt withholds the request without touching the flag
      next_state.irq = next_state.irq_enable && next_state.irq_flag && !dbg_sync;  // [RULE7] [RULE8]
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state            <= '0;   // [RULE6]
         state.phase      <= phase_idle;
         state.ready      <= 1'b1;
         state.level_sel  <= reg_reset_value[1:0];
         state.edge_cfg   <= reg_reset_value[2:1];
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Zero wait states: ready is a flop held high, even in reset, so the bus never stalls
   assign hreadyout_o         = state.ready;
   assign hresp_o             = state.resp;
   assign hrdata_o            = state.rdata;
   assign monitor_level_sel_o = state.level_sel;
   assign monitor_irq_o       = state.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   irq_gating_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      monitor_irq_o |-> state.irq_enable && state.irq_flag)   // [RULE7]
      else $error("irq without enable and flag");
   irq_debug_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      dbg_sync |=> !monitor_irq_o)   // [RULE8]
      else $error("irq during debug halt");
   flag_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !bod_sync |=> $stable(state.irq_flag))   // [RULE5]
      else $error("flag changed while detector off");
   flag_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cross_hit && bod_sync |=> state.irq_flag)   // [RULE4]
      else $error("crossing did not set flag");
   flag_only_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(state.irq_flag) |-> $past(cross_hit))   // [RULE4]
      else $error("flag set without crossing");
   off_no_hit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state.level_sel == level_off |-> !cross_hit)   // [RULE1]
      else $error("crossing while monitor off");
   reserved_cfg_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state.edge_cfg == 2'h3 |-> !cross_hit)   // [RULE2]
      else $error("reserved edge code triggered");
   enable_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state.phase == phase_data && state.wr_pend
      && state.addr_idx == monitor_interrupt_control_idx
      |=> state.irq_enable == $past(hwdata_i[irq_enable_bit]))   // [RULE3]
      else $error("enable write lost");
   clear_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      state.irq_flag && !(state.phase == phase_data && state.wr_pend) |=> state.irq_flag)  // [RULE9]
      else $error("flag cleared without write");

   irq_seen_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(monitor_irq_o));
   clear_seen_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $fell(state.irq_flag));
   both_cfg_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      cross_hit && state.edge_cfg == edge_both);
   debug_mask_c: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      dbg_sync && state.irq_enable && state.irq_flag);

endmodule

// ### supply_level_monitor_pkg.sv
// Constants shared by the supply level monitor register bank
package supply_level_monitor_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] monitor_level_control_idx     = 8'h08;
   localparam logic [7:0] monitor_interrupt_control_idx = 8'h09;
   localparam logic [7:0] monitor_interrupt_flags_idx   = 8'h0a;
   localparam logic [7:0] monitor_status_idx            = 8'h0b;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         level_sel_lsb   = 0;
   localparam int         edge_cfg_lsb    = 1;
   localparam int         irq_enable_bit  = 0;
   localparam int         irq_flag_bit    = 0;
   localparam int         below_bit       = 0;
   localparam logic [7:0] reg_reset_value = 8'h00;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] level_off     = 2'h0;
   localparam logic [1:0] level_5above  = 2'h1;
   localparam logic [1:0] level_15above = 2'h2;
   localparam logic [1:0] level_25above = 2'h3;
   localparam logic [1:0] edge_falling  = 2'h0;
   localparam logic [1:0] edge_rising   = 2'h1;
   localparam logic [1:0] edge_both     = 2'h2;

   // AHB-Lite codes
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [2:0] hsize_word    = 3'h2;

   // Bus slave phase machine
   typedef enum logic [1:0]
   {
      phase_idle = 2'b01,
      phase_data = 2'b10
   } phase_type;

endpackage

// ### level_sync.sv
// Two-flop synchroniser for asynchronous single-bit levels
`timescale 1ns/1ps
module level_sync
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   // Level
   input  wire logic async_i,
   output logic      sync_o
);

   typedef struct packed
   {
      logic first;
      logic second;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   always_comb
   begin
      next_state.first  = async_i;
      next_state.second = state.first;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign sync_o = state.second;

endmodule

// ### supply_comparator_model.sv
// Behavioural model of the supply comparator and detector enable
`timescale 1ns/1ps
module supply_comparator_model
(
   // Clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   // Commands from the bench
   input  wire logic       below_cmd_i,
   input  wire logic       enable_cmd_i,
   input  wire logic [1:0] level_sel_i,
   // Comparator side
   output logic            supply_below_o,
   output logic            brownout_enabled_o
);
   // ----------------------------------------------------------------
   // Comparator
   // ----------------------------------------------------------------
   // An unpowered comparator reports above, so level off reads as above
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         supply_below_o     <= 1'b0;
         brownout_enabled_o <= 1'b0;
      end
      else
      begin
         supply_below_o     <= below_cmd_i && (level_sel_i != 2'h0);
         brownout_enabled_o <= enable_cmd_i;
      end
   end
endmodule

// ### supply_level_monitor_regs_tb_top.sv
// Self-checking bench of the supply level monitor register bank
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module supply_level_monitor_regs_tb_top
   import supply_level_monitor_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        sys_clk_i, rst_b_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, d;
   logic [1:0]  htrans_i, level_sel;
   logic [2:0]  hsize_i;
   logic        supply_below, bod_en, below_cmd, enable_cmd, debug_halted_i, irq;
   int          miscompares, num_checks, cycles;

   supply_level_monitor_regs dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .supply_below_i(supply_below), .brownout_enabled_i(bod_en),
      .debug_halted_i(debug_halted_i), .monitor_level_sel_o(level_sel),
      .monitor_irq_o(irq));
   supply_comparator_model model_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .below_cmd_i(below_cmd), .enable_cmd_i(enable_cmd), .level_sel_i(level_sel),
      .supply_below_o(supply_below), .brownout_enabled_o(bod_en));

   // ----------------------------------------------------------------
   // Bus and timing helpers
   // ----------------------------------------------------------------
   task automatic wait_ready();
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
   endtask

   // Single word transfer; read data is taken at the data phase's edge
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel_i   <= 1'b1;
      htrans_i <= htrans_nonseq;
      haddr_i  <= {22'h0, idx, 2'h0};
      hwrite_i <= wr;
      wait_ready();
      hsel_i   <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      wait_ready();
      d = hrdata_o;
   endtask

   // Crossings need the model flop, two sync flops and one stage that loads flag and request together
   task automatic settle();
      repeat (8) @(posedge sys_clk_i);
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      bus(1'b1, 8'h0c, 32'hff);
      for (int i = 8; i < 13; i++)
      begin
         bus(1'b0, 8'(i), 32'h0);
         `CHK(d, 32'h0);
         `CHK(hresp_o, 1'b0);
      end
   endtask

   task automatic t_level();
      for (int i = 3; i >= 0; i--)
      begin
         bus(1'b1, monitor_level_control_idx, 32'(i));
         bus(1'b0, monitor_level_control_idx, 32'h0);
         `CHK(d, 32'(i));
         `CHK(level_sel, 2'(i));
      end
      bus(1'b1, monitor_level_control_idx, {30'h0, level_5above});
   endtask

   task automatic t_edges();
      logic [1:0] c;
      enable_cmd <= 1'b1;
      settle();
      for (int i = 0; i < 4; i++)
      begin
         c = 2'(i);
         bus(1'b1, monitor_interrupt_control_idx, {29'h0, c, 1'b0});
         below_cmd <= 1'b1;
         settle();
         bus(1'b0, monitor_interrupt_flags_idx, 32'h0);
         `CHK(d[0], (c == edge_falling) || (c == edge_both));
         `CHK(irq, 1'b0);
         bus(1'b0, monitor_status_idx, 32'h0);
         `CHK(d, 32'h1);
         bus(1'b1, monitor_interrupt_flags_idx, 32'h1);
         below_cmd <= 1'b0;
         settle();
         bus(1'b0, monitor_interrupt_flags_idx, 32'h0);
         `CHK(d[0], (c == edge_rising) || (c == edge_both));
         bus(1'b1, monitor_interrupt_flags_idx, 32'h1);
      end
   endtask

   task automatic t_irq();
      bus(1'b1, monitor_interrupt_control_idx, {29'h0, edge_falling, 1'b1});
      below_cmd <= 1'b1;
      settle();
      `CHK(irq, 1'b1);
      debug_halted_i <= 1'b1;
      settle();
      `CHK(irq, 1'b0);
      debug_halted_i <= 1'b0;
      bus(1'b1, monitor_interrupt_flags_idx, 32'h0);
      settle();
      `CHK(irq, 1'b1);
      bus(1'b1, monitor_interrupt_flags_idx, 32'h1);
      settle();
      `CHK(irq, 1'b0);
      below_cmd <= 1'b0;
      enable_cmd <= 1'b0;
      settle();
   endtask

   // Flag must neither set nor clear while the detector is off
   task automatic t_hold();
      below_cmd <= 1'b1;
      settle();
      bus(1'b0, monitor_interrupt_flags_idx, 32'h0);
      `CHK(d, 32'h0);
      below_cmd <= 1'b0;
      enable_cmd <= 1'b1;
      settle();
      below_cmd <= 1'b1;
      settle();
      `CHK(irq, 1'b1);
      enable_cmd <= 1'b0;
      settle();
      bus(1'b1, monitor_interrupt_flags_idx, 32'h1);
      settle();
      bus(1'b0, monitor_interrupt_flags_idx, 32'h0);
      `CHK(d, 32'h1);
   endtask

   // ----------------------------------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   initial
   begin
      {rst_b_i, hsel_i, hwrite_i, below_cmd, enable_cmd, debug_halted_i} = '0;
      {haddr_i, hwdata_i, htrans_i} = '0;
      hsize_i = hsize_word;
      repeat (2) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
      t_reset();
      t_level();
      t_edges();
      t_irq();
      t_hold();
      report_and_stop();
   end
endmodule
